// file: rtl/display_cmd_decoder.sv
// Purpose: byte command decoder of a bistable dot-matrix display driver
// Assumes: host bytes arrive as APB writes; display memory sits outside
// Notes: PREADY tied high; every access takes two cycles
`timescale 1ns/1ps
`default_nettype none
module display_cmd_decoder
    import display_cmd_pkg::*;
#(
    parameter int PHASE_UNIT = 16,
    parameter int STEP_CYCLES = 32
)(
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic MEM_WE,
    output logic [7:0] MEM_COL,
    output logic [2:0] MEM_PAGE,
    output logic [7:0] MEM_WDATA,
    input wire logic [7:0] MEM_RDATA,
    output disp_cfg_t DISP_CFG,
    output drive_cfg_t DRIVE_CFG,
    output power_t POWER,
    output phase_t PHASE,
    output logic POLARITY,
    output logic INNER_FOLLOW_ONE,
    output logic BORDER_FOLLOW_ONE
);
    // ****************************************
    // bus decode
    // ****************************************
    logic setup;
    logic access;
    logic wr_cmd;
    logic wr_data;
    logic rd_data;
    logic hit;
    logic [7:0] byte_in;
    logic locked_reg;
    logic busy;
    assign setup = PSEL && !PENABLE;
    assign access = PSEL && PENABLE;
    assign byte_in = PWDATA[7:0];
    always_comb
    begin
        if (PADDR == ADDR_CMD)
            hit = PWRITE;
        else if (PADDR == ADDR_DATA)
            hit = 1'b1;
        else if (PADDR == ADDR_STATUS)
            hit = !PWRITE;
        else
            hit = 1'b0;
    end
    assign PREADY = 1'b1;
    assign PSLVERR = access && !hit;
    assign wr_cmd = access && PWRITE && PADDR == ADDR_CMD;
    assign wr_data = access && PWRITE && PADDR == ADDR_DATA
        && !locked_reg;
    assign rd_data = access && !PWRITE && PADDR == ADDR_DATA;

    // ****************************************
    // opcode and parameter tracking
    // ****************************************
    logic [7:0] op_reg;
    logic [3:0] left_reg;
    logic [3:0] idx_reg;
    logic is_param;
    logic new_op;
    logic take_op;
    logic take_par;
    logic [3:0] n_params;
    assign is_param = left_reg != 4'h0;
    assign new_op = wr_cmd && !is_param;
    // locked: only the lock opcode and its parameter pass
    assign take_op = new_op && (!locked_reg || byte_in == OP_LOCK);
    assign take_par = wr_cmd && is_param
        && (!locked_reg || op_reg == OP_LOCK);
    always_comb
    begin
        n_params = 4'h0;
        if (byte_in == OP_CTRL)
            n_params = CTRL_BYTES;
        else if (byte_in inside {OP_SCHEME, OP_BIAS, OP_ANALOG, OP_ROWS,
            OP_AUTO, OP_DIR, OP_THR, OP_OFFSET, OP_LADDER, OP_OSC, OP_LOCK,
            OP_CLKEN, [OP_REP0:OP_REP4]})
            n_params = 4'h1;
    end
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            op_reg <= 8'h00;
            left_reg <= 4'h0;
            idx_reg <= 4'h0;
        end
        else if (take_op)
        begin
            op_reg <= byte_in;
            left_reg <= n_params;
            idx_reg <= 4'h0;
        end
        else if (wr_cmd && is_param)
        begin
            left_reg <= left_reg - 4'h1;
            idx_reg <= idx_reg + 4'h1;
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    logic [7:0] scheme_reg;
    logic [6:0] thr_reg;
    drive_cfg_t stage_reg;
    disp_cfg_t disp_reg;
    logic [3:0] rep_reg [5];
    logic [6:0] off_max;
    logic par_is_rep;
    assign off_max = ROWS_RST - disp_reg.rows;
    assign par_is_rep = op_reg inside {[OP_REP0:OP_REP4]};
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            disp_reg <= '0;
            disp_reg.rows <= ROWS_RST;
            scheme_reg <= SCHEME_RST;
            thr_reg <= THR_RST;
            stage_reg <= '0;
            locked_reg <= LOCK_RST[LOCK_BIT];
        end
        else if (take_op)
        begin
            if (byte_in[7:1] == 7'h50)
                disp_reg.seg_remap <= byte_in[0];
            else if (byte_in[7:1] == 7'h52)
                disp_reg.all_on <= byte_in[0];
            else if (byte_in[7:1] == 7'h53)
                disp_reg.invert <= byte_in[0];
            else if (byte_in[7:6] == 2'b01)
                disp_reg.start_line <= byte_in[5:0];
            else if ({byte_in[7:4], byte_in[2:0]} == 7'h60)
                disp_reg.com_rev <= byte_in[3];
        end
        else if (take_par)
        begin
            if (op_reg == OP_CTRL)
            begin
                // byte 0 is a fixed zero
                if (idx_reg == 4'h1)
                    stage_reg.outer <= byte_in[4:0];
                else if (idx_reg == 4'h2)
                    stage_reg.idle1 <= byte_in[4:0];
                else if (idx_reg == 4'h3)
                    stage_reg.inner <= byte_in[4:0];
                else if (idx_reg == 4'h4)
                    stage_reg.idle2 <= byte_in[4:0];
                else if (idx_reg == 4'h5)
                    stage_reg.drive <= byte_in[4:0];
                else if (idx_reg == 4'h6)
                    stage_reg.clr_v <= byte_in[6:1];
                else if (idx_reg == 4'h7)
                    stage_reg.drv_v <= byte_in[6:1];
            end
            else if (op_reg == OP_SCHEME)
                scheme_reg <= byte_in;
            else if (op_reg == OP_BIAS)
                disp_reg.bias <= byte_in[2:0];
            else if (op_reg == OP_ROWS)
            begin
                if (byte_in[6:0] >= ROWS_MIN && byte_in[6:0] <= ROWS_RST)
                    disp_reg.rows <= byte_in[6:0];
            end
            else if (op_reg == OP_DIR)
                disp_reg.vertical <= byte_in[0];
            else if (op_reg == OP_THR)
                thr_reg <= byte_in[6:0];
            else if (op_reg == OP_OFFSET)
            begin
                if ({1'b0, byte_in[5:0]} <= off_max)
                    disp_reg.offset <= byte_in[5:0];
            end
            else if (op_reg == OP_LOCK)
                locked_reg <= byte_in[LOCK_BIT];
        end
    end
    // one repeat count per phase, indexed by opcode
    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : g_rep
            always_ff @(posedge CLOCK or negedge RESET_N)
            begin
                if (!RESET_N)
                    rep_reg[g] <= REP_RST;
                else if (take_par && par_is_rep
                    && op_reg[2:0] == 3'(g + 3))
                    rep_reg[g] <= byte_in[3:0];
            end
        end
    endgenerate

    // ****************************************
    // memory pointer
    // ****************************************
    logic [7:0] col_reg;
    logic [2:0] page_reg;
    logic [7:0] rd_hold_reg;
    logic step;
    assign step = wr_data || rd_data;
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            col_reg <= 8'h00;
            page_reg <= 3'h0;
        end
        else if (take_op && byte_in == OP_SWRST)
        begin
            col_reg <= 8'h00;
            page_reg <= 3'h0;
        end
        else if (take_op && byte_in[7:4] == 4'h1)
            col_reg <= {byte_in[3:0], col_reg[3:0]};
        else if (take_op && byte_in[7:4] == 4'h0)
            col_reg <= {col_reg[7:4], byte_in[3:0]};
        else if (take_op && byte_in[7:3] == 5'h16)
            page_reg <= byte_in[2:0];
        else if (step && !disp_reg.vertical)
        begin
            if (col_reg == COL_LAST)
            begin
                col_reg <= 8'h00;
                page_reg <= page_reg + 3'h1;
            end
            else
                col_reg <= col_reg + 8'h01;
        end
        else if (step)
        begin
            page_reg <= page_reg + 3'h1;
            if (page_reg == PAGE_LAST)
                col_reg <= (col_reg == COL_LAST) ? 8'h00 : col_reg + 8'h01;
        end
    end
    // data writes leave on the pointer value of the access cycle
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            MEM_WE <= 1'b0;
            MEM_COL <= 8'h00;
            MEM_PAGE <= 3'h0;
            MEM_WDATA <= 8'h00;
        end
        else
        begin
            MEM_WE <= wr_data;
            MEM_COL <= col_reg;
            MEM_PAGE <= page_reg;
            MEM_WDATA <= byte_in;
        end
    end
    // each read returns what the previous read fetched: dummy first
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
            rd_hold_reg <= 8'h00;
        else if (rd_data)
            rd_hold_reg <= MEM_RDATA;
    end

    // ****************************************
    // read data
    // ****************************************
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
            PRDATA <= '0;
        else if (setup && !PWRITE && PADDR == ADDR_STATUS)
            PRDATA <= {24'h0, busy, disp_reg.seg_remap,
                !POWER.clock_en, 1'b0, ID_CODE};
        else if (setup && !PWRITE && PADDR == ADDR_DATA)
            PRDATA <= {24'h0, rd_hold_reg};
        else if (setup)
            PRDATA <= '0;
    end

    // ****************************************
    // power control
    // ****************************************
    logic pwr_run_reg;
    logic pwr_on_reg;
    logic [1:0] pwr_step_reg;
    logic [$clog2(STEP_CYCLES)-1:0] pwr_tmr_reg;
    logic pwr_tick;
    assign pwr_tick = pwr_run_reg
        && pwr_tmr_reg == ($clog2(STEP_CYCLES))'(STEP_CYCLES - 1);
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            POWER <= '0;
            POWER.pump_en <= POWER_RST[2];
            POWER.buf_en <= POWER_RST[0];
            pwr_run_reg <= 1'b0;
            pwr_on_reg <= 1'b0;
            pwr_step_reg <= 2'h0;
            pwr_tmr_reg <= '0;
        end
        else
        begin
            POWER.pump_16x <= DRIVE_CFG.drv_v > thr_reg[6:1];
            if (pwr_run_reg)
                pwr_tmr_reg <= pwr_tick ? '0 : pwr_tmr_reg + 1'b1;
            if (take_op && byte_in[7:3] == 5'h05 && byte_in[1])
            begin
                POWER.pump_en <= byte_in[2];
                POWER.buf_en <= byte_in[0];
            end
            else if (take_par && op_reg == OP_AUTO)
            begin
                pwr_run_reg <= 1'b1;
                pwr_on_reg <= byte_in[0];
                pwr_step_reg <= 2'h0;
                pwr_tmr_reg <= '0;
            end
            else if (take_par && op_reg == OP_ANALOG)
            begin
                if (byte_in[4:3] == 2'b11)
                    POWER.analog_en <= 1'b1;
                else if (byte_in[4:3] == 2'b00)
                    POWER.analog_en <= 1'b0;
                POWER.buf_extra <= byte_in[1];
            end
            else if (take_par && op_reg == OP_LADDER)
                POWER.ladder_en <= byte_in[7];
            else if (take_par && op_reg == OP_OSC)
                POWER.osc_en <= byte_in[6];
            else if (take_par && op_reg == OP_CLKEN)
                POWER.clock_en <= byte_in[7];
            else if (pwr_tick)
            begin
                pwr_step_reg <= pwr_step_reg + 2'h1;
                if (pwr_step_reg == 2'h3)
                    pwr_run_reg <= 1'b0;
                case (pwr_step_reg)
                    2'h0:
                        if (pwr_on_reg)
                            POWER.analog_en <= 1'b1;
                        else
                            POWER.pump_en <= 1'b0;
                    2'h1:
                        if (pwr_on_reg)
                            POWER.osc_en <= 1'b1;
                        else
                            POWER.buf_en <= 1'b0;
                    2'h2:
                        if (pwr_on_reg)
                            POWER.buf_en <= 1'b1;
                        else
                            POWER.osc_en <= 1'b0;
                    default:
                        if (pwr_on_reg)
                            POWER.pump_en <= 1'b1;
                        else
                            POWER.analog_en <= 1'b0;
                endcase
            end
        end
    end

    // ****************************************
    // driving update sequencer
    // ****************************************
    logic [3:0] rep_left_reg;
    logic [20:0] tmr_reg;
    logic [20:0] span;
    logic [4:0] dur;
    logic [3:0] rep_next;
    phase_t ph_next;
    logic ph_done;
    assign busy = PHASE != PH_IDLE || pwr_run_reg;
    always_comb
    begin
        dur = DRIVE_CFG.outer;
        rep_next = rep_reg[1];
        ph_next = PH_IDLE;
        case (PHASE)
            PH_OUTER:
                ph_next = PH_IDLE1;
            PH_IDLE1:
            begin
                dur = DRIVE_CFG.idle1;
                ph_next = PH_INNER;
                rep_next = rep_reg[2];
            end
            PH_INNER:
            begin
                dur = DRIVE_CFG.inner;
                ph_next = PH_IDLE2;
                rep_next = rep_reg[3];
            end
            PH_IDLE2:
            begin
                dur = DRIVE_CFG.idle2;
                ph_next = PH_DRIVE;
                rep_next = rep_reg[4];
            end
            PH_DRIVE:
                dur = DRIVE_CFG.drive;
            default: ;
        endcase
    end
    assign span = 21'((dur + 6'h01) * PHASE_UNIT);
    assign ph_done = rep_left_reg == 4'h0
        || (rep_left_reg == 4'h1 && tmr_reg == span - 21'h1);
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            PHASE <= PH_IDLE;
            DRIVE_CFG <= '0;
            rep_left_reg <= 4'h0;
            tmr_reg <= 21'h0;
            POLARITY <= 1'b1;
        end
        else
        begin
            case (PHASE)
                PH_IDLE:
                    if (take_op && byte_in == OP_UPDATE)
                    begin
                        DRIVE_CFG <= stage_reg;
                        PHASE <= PH_OUTER;
                        rep_left_reg <= rep_reg[0];
                        tmr_reg <= 21'h0;
                        POLARITY <= !scheme_reg[2];
                    end
                default:
                    if (ph_done)
                    begin
                        // a zero count ends its phase after one cycle
                        PHASE <= ph_next;
                        rep_left_reg <= rep_next;
                        tmr_reg <= 21'h0;
                        if (ph_next == PH_INNER)
                            POLARITY <= !scheme_reg[2];
                        else if (ph_next == PH_DRIVE)
                            POLARITY <= !scheme_reg[3];
                    end
                    else if (tmr_reg == span - 21'h1)
                    begin
                        rep_left_reg <= rep_left_reg - 4'h1;
                        tmr_reg <= 21'h0;
                        POLARITY <= !POLARITY;
                    end
                    else
                        tmr_reg <= tmr_reg + 21'h1;
            endcase
        end
    end
    assign DISP_CFG = disp_reg;
    assign INNER_FOLLOW_ONE = scheme_reg[6:5] == 2'b01;
    assign BORDER_FOLLOW_ONE = scheme_reg[4] && scheme_reg[1];
endmodule : display_cmd_decoder
`default_nettype wire

// file: pkg/display_cmd_pkg.sv
// Purpose: shared constants and types of the display command decoder
// Assumes: one 200 MHz clock, APB register access
// Notes: opcodes are the driver's byte commands
package display_cmd_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] ADDR_CMD = 12'h000;
    localparam logic [11:0] ADDR_DATA = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [3:0] ID_CODE = 4'h5; // arbitrary value
    localparam int ST_BUSY = 7;
    localparam int ST_REMAP = 6;
    localparam int ST_OFF = 5;
    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [7:0] OP_UPDATE = 8'h31;
    localparam logic [7:0] OP_SCHEME = 8'h32;
    localparam logic [7:0] OP_CTRL = 8'h80;
    localparam logic [7:0] OP_REP0 = 8'h93;
    localparam logic [7:0] OP_REP4 = 8'h97;
    localparam logic [7:0] OP_BIAS = 8'ha2;
    localparam logic [7:0] OP_ANALOG = 8'ha3;
    localparam logic [7:0] OP_ROWS = 8'ha8;
    localparam logic [7:0] OP_AUTO = 8'ha9;
    localparam logic [7:0] OP_DIR = 8'had;
    localparam logic [7:0] OP_THR = 8'hae;
    localparam logic [7:0] OP_OFFSET = 8'hd3;
    localparam logic [7:0] OP_SWRST = 8'he2;
    localparam logic [7:0] OP_LADDER = 8'he9;
    localparam logic [7:0] OP_OSC = 8'hf6;
    localparam logic [7:0] OP_LOCK = 8'hfd;
    localparam logic [7:0] OP_CLKEN = 8'hfe;
    localparam logic [3:0] CTRL_BYTES = 4'h8;
    // ****************************************
    // reset values and limits
    // ****************************************
    localparam logic [7:0] POWER_RST = 8'h2a;
    localparam logic [7:0] SCHEME_RST = 8'h00;
    localparam logic [3:0] REP_RST = 4'h1;
    localparam logic [6:0] ROWS_RST = 7'h40;
    localparam logic [6:0] ROWS_MIN = 7'h02;
    localparam logic [6:0] THR_RST = 7'h20;
    localparam logic [7:0] COL_LAST = 8'h83;
    localparam logic [2:0] PAGE_LAST = 3'h7;
    localparam logic [7:0] LOCK_RST = 8'h12;
    localparam int LOCK_BIT = 2;
    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [4:0] outer;
        logic [4:0] idle1;
        logic [4:0] inner;
        logic [4:0] idle2;
        logic [4:0] drive;
        logic [5:0] clr_v;
        logic [5:0] drv_v;
    } drive_cfg_t;
    typedef struct packed {
        logic [5:0] start_line;
        logic [5:0] offset;
        logic [6:0] rows;
        logic seg_remap;
        logic com_rev;
        logic all_on;
        logic invert;
        logic vertical;
        logic [2:0] bias;
    } disp_cfg_t;
    typedef struct packed {
        logic analog_en;
        logic osc_en;
        logic buf_en;
        logic pump_en;
        logic buf_extra;
        logic ladder_en;
        logic clock_en;
        logic pump_16x;
    } power_t;
    typedef enum logic [2:0] {
        PH_IDLE, PH_OUTER, PH_IDLE1, PH_INNER, PH_IDLE2, PH_DRIVE
    } phase_t;
endpackage : display_cmd_pkg

// file: bench/display_cmd_asserts.sv
// Purpose: port checker of the display command decoder
// Assumes: one clock domain, reset active low
// Notes: bound to every decoder instance below
`timescale 1ns/1ps
`default_nettype none
module display_cmd_asserts
    import display_cmd_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    input wire logic MEM_WE,
    input wire logic [7:0] MEM_WDATA,
    input wire disp_cfg_t DISP_CFG,
    input wire drive_cfg_t DRIVE_CFG,
    input wire power_t POWER,
    input wire phase_t PHASE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    sequence s_st_rd;
        PSEL && PENABLE && !PWRITE && PADDR == ADDR_STATUS;
    endsequence
    sequence s_st_wr;
        PSEL && PENABLE && PWRITE && PADDR == ADDR_STATUS;
    endsequence
    chk_status_fixed: assert property (s_st_rd |->
        PRDATA[4:0] == {1'b0, ID_CODE} && PRDATA[ST_OFF] == !POWER.clock_en
        && PRDATA[ST_REMAP] == DISP_CFG.seg_remap) else $error("status");
    chk_status_busy: assert property (
        s_st_rd ##0 $past(PHASE) != PH_IDLE |-> PRDATA[ST_BUSY])
        else $error("busy bit");
    chk_status_ro: assert property (s_st_wr |-> PSLVERR)
        else $error("status write accepted");
    chk_we_cause: assert property (MEM_WE |-> $past(PWRITE) &&
        $past(PENABLE) && $past(PADDR) == ADDR_DATA) else $error("stray we");
    chk_we_data: assert property (
        MEM_WE |-> MEM_WDATA == 8'($past(PWDATA))) else $error("we data");
    chk_we_pulse: assert property (MEM_WE |=> !MEM_WE)
        else $error("we too long");
    chk_phase_order: assert property (PHASE != $past(PHASE) |->
        PHASE == PH_IDLE || PHASE == $past(PHASE) + 3'd1)
        else $error("phase order");
    chk_rows_range: assert property (
        DISP_CFG.rows inside {[ROWS_MIN:7'd64]}) else $error("rows");
    chk_cfg_latch: assert property ($changed(DRIVE_CFG) |->
        $past(PHASE) == PH_IDLE) else $error("drive cfg moved");
endmodule : display_cmd_asserts
bind display_cmd_decoder display_cmd_asserts display_cmd_asserts_i (
    .CLOCK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PSLVERR, .MEM_WE, .MEM_WDATA, .DISP_CFG, .DRIVE_CFG, .POWER, .PHASE);
`default_nettype wire

// file: bench/display_mem_model.sv
// Purpose: display memory behind the decoder
// Assumes: byte write on MEM_WE, read follows the address at once
// Notes: unwritten bytes hold an address pattern, never a constant
`timescale 1ns/1ps
`default_nettype none
module display_mem_model (
    input wire logic CLOCK,
    input wire logic MEM_WE,
    input wire logic [7:0] MEM_COL,
    input wire logic [2:0] MEM_PAGE,
    input wire logic [7:0] MEM_WDATA,
    output logic [7:0] MEM_RDATA
);
    logic [7:0] mem [2048];
    initial for (int i = 0; i < 2048; i++) mem[i] = 8'(i) ^ 8'ha5;
    always @(posedge CLOCK) if (MEM_WE) mem[{MEM_PAGE, MEM_COL}] <= MEM_WDATA;
    assign MEM_RDATA = mem[{MEM_PAGE, MEM_COL}];
endmodule : display_mem_model
`default_nettype wire

// file: bench/bistable_display_command_decoder_tb.sv
// Purpose: self-checking bench of the display command decoder
// Assumes: APB host, short phase and power step counts
// Notes: reads and memory writes are checked from queues by a monitor
`timescale 1ns/1ps
`default_nettype none
module bistable_display_command_decoder_tb;
    import display_cmd_pkg::*;
    logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, mem_we, polarity, inner1, border1;
    logic [7:0] mem_col, mem_wdata, mem_rdata, d[2];
    logic [2:0] mem_page;
    disp_cfg_t dcfg;
    drive_cfg_t vcfg;
    power_t pwr;
    phase_t phase, ph;
    logic [8:0] exp_rd[$];
    logic [18:0] exp_wr[$];
    int fails = 0, compares = 0;
    logic [167:0] cfg_bytes = 168'ha820a801d31055c8a5a7a203a31ae980f640ae5be3;
    always #2.5 clock = ~clock;
    display_cmd_decoder #(.PHASE_UNIT(2), .STEP_CYCLES(2))
        display_cmd_decoder_i (.CLOCK(clock), .RESET_N(reset_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .MEM_WE(mem_we), .MEM_COL(mem_col),
        .MEM_PAGE(mem_page), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
        .DISP_CFG(dcfg), .DRIVE_CFG(vcfg), .POWER(pwr), .PHASE(phase),
        .POLARITY(polarity), .INNER_FOLLOW_ONE(inner1),
        .BORDER_FOLLOW_ONE(border1));
    display_mem_model display_mem_model_i (.CLOCK(clock), .MEM_WE(mem_we),
        .MEM_COL(mem_col), .MEM_PAGE(mem_page), .MEM_WDATA(mem_wdata),
        .MEM_RDATA(mem_rdata));
    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic check(string what, logic [39:0] e, logic [39:0] g);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", what, e, g);
        end
    endtask : check
    task automatic apb(logic wr, logic [11:0] a, logic [7:0] v);
        int n;
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, v};
        @(posedge clock);
        penable <= 1;
        n = 0;
        do @(posedge clock); while (pready !== 1'b1 && ++n < 50);
        if (n == 50)
        begin
            check("pready", 1, 0);
            complete_run();
        end
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask : apb
    task automatic cmd(logic [7:0] v);
        apb(1, ADDR_CMD, v);
    endtask : cmd
    task automatic wr(logic [7:0] v, logic [2:0] p, logic [7:0] c);
        exp_wr.push_back({p, c, v});
        apb(1, ADDR_DATA, v);
    endtask : wr
    task automatic rd(logic care, logic [7:0] v, logic [11:0] a);
        exp_rd.push_back({care, v});
        apb(0, a, 8'h00);
    endtask : rd
    task automatic auto_pwr(logic on);
        logic [3:0] p;
        cmd(OP_AUTO);
        cmd({7'h0, on});
        for (int n = 0; n < 300 && pwr[7:4] !== {4{on}}; n++)
        begin
            @(posedge clock);
            p = on ? pwr[7:4] : ~{pwr[4], pwr[5], pwr[6], pwr[7]};
            if (!(p inside {4'h0, 4'h8, 4'hc, 4'he, 4'hf}))
                check("power order", 0, p);
        end
        check("power auto", {4{on}}, pwr[7:4]);
    endtask : auto_pwr
    always @(posedge clock)
    begin
        logic [8:0] e;
        if (psel && penable && !pwrite)
        begin
            e = exp_rd.size() ? exp_rd.pop_front() : 9'h100;
            if (e[8]) check("read", e[7:0], prdata[7:0]);
        end
        if (mem_we === 1'b1)
            check("mem write", exp_wr.size() ? exp_wr.pop_front() : 0,
                {mem_page, mem_col, mem_wdata});
    end
    initial
    begin
        void'($urandom(32'hddbbdc2b));
        repeat (6) @(posedge clock);
        reset_n <= 1;
        @(posedge clock);
        check("rows", ROWS_RST, dcfg.rows);
        check("power", 8'h00, pwr);
        rd(1, 8'h25, ADDR_STATUS);
        $display("test reset done");
        for (int v = 0; v < 2; v++)
        begin
            foreach (d[i]) d[i] = 8'($urandom());
            cmd(OP_DIR);
            cmd(8'(v));
            for (int k = 0; k < 2; k++)
            begin
                cmd(v ? 8'h12 : 8'h18);
                cmd(v ? 8'h05 : 8'h03);
                cmd(8'hb7);
                if (k == 0)
                begin
                    wr(d[0], 3'h7, v ? 8'h25 : 8'h83);
                    rd(1, 8'h25, ADDR_STATUS);
                    wr(d[1], 3'h0, v ? 8'h26 : 8'h00);
                end
            end
            rd(0, 8'h00, ADDR_DATA);
            rd(1, d[0], ADDR_DATA);
            rd(1, d[1], ADDR_DATA);
        end
        $display("test pointer done");
        cmd(OP_LOCK);
        cmd(8'h04);
        apb(1, ADDR_DATA, 8'h5a);
        apb(1, ADDR_STATUS, 8'h5a);
        cmd(8'ha1);
        rd(1, 8'h25, ADDR_STATUS);
        cmd(OP_LOCK);
        cmd(8'h00);
        cmd(8'ha1);
        rd(1, 8'h65, ADDR_STATUS);
        $display("test lock done");
        for (int i = 20; i >= 0; i--)
            cmd(cfg_bytes[i*8+:8]);
        check("disp cfg", {6'h15, 6'h10, 7'h20, 5'h1f, 3'h3},
            dcfg);
        cmd(8'h2f);
        check("power", 8'hfc, pwr);
        cmd(8'h2a);
        auto_pwr(1);
        cmd(OP_CLKEN);
        cmd(8'h80);
        auto_pwr(0);
        $display("test power done");
        cmd(OP_CTRL);
        cmd(8'h00);
        for (int i = 4; i < 9; i++) cmd(8'(i));
        cmd(8'h30);
        cmd(8'h5c);
        for (int op = OP_REP0; op <= OP_REP4; op++)
        begin
            cmd(8'(op));
            cmd(op == OP_REP4 ? 8'h02 : 8'h01);
        end
        cmd(OP_SCHEME);
        cmd(8'h32);
        cmd(OP_UPDATE);
        check("drive cfg", {25'h04298e8, 6'h18, 6'h2e}, vcfg);
        check("phase", PH_OUTER, phase);
        check("polarity", 1, polarity);
        check("follow", 2'b11, {inner1, border1});
        rd(1, 8'hc5, ADDR_STATUS);
        check("pump 16x", 1, pwr.pump_16x);
        ph = PH_OUTER;
        for (int n = 0; n < 3000 && ph != PH_IDLE; n++)
        begin
            @(posedge clock);
            if (phase !== ph)
            begin
                check("phase", ph == PH_DRIVE ? 0 : ph + 1, phase);
                ph = phase;
            end
        end
        check("queues", 0, exp_rd.size() + exp_wr.size() + (ph != 0));
        $display("test update done");
        complete_run();
    end
endmodule : bistable_display_command_decoder_tb
`default_nettype wire
